// ---- src/qbpp_pkg.sv ----
// Behaviour
// - Quasi mode: latch one enables very-weak pull-up
// - Quasi weak pull-up needs latch and pin high
// - Strong pull-up two clocks after output rises
// - Input-only: no pull-ups, no drivers
// - Push-pull drives pin high and low
// - Open-drain pulls low only, never high
// - Reset: latches one, mode bits zero
// - Writes reach the pin only in output modes
// - Plain reads return synchronised pin levels
// - Read-modify-write reads the latch, not pins
// - Two mode bits select the pin structure
package qbpp_pkg;

    // ****************************************
    // Structure codes and defaults
    // ****************************************
    typedef enum logic [1:0] {
        QBPP_QUASI = 2'b00,
        QBPP_PUSH_PULL = 2'b01,
        QBPP_INPUT_ONLY = 2'b10,
        QBPP_OPEN_DRAIN = 2'b11
    } qbpp_mode_type;

    localparam int QBPP_WIDTH = 8;
    localparam logic QBPP_LATCH_RST = 1'h1;
    localparam logic QBPP_MODE_RST = 1'h0;
    localparam int QBPP_STRONG_DELAY_CLKS = 2;
    localparam int QBPP_SYNC_STAGES = 2;

    typedef struct packed {
        logic outVal;
        logic outEn;
        logic veryWeakPu;
        logic weakPu;
        logic strongPu;
    } qbpp_drive_type;

    typedef struct packed {
        logic wrEn;
        logic rmwRead;
        logic [QBPP_WIDTH-1:0] wrData;
    } qbpp_cpu_type;

endpackage

// ---- src/qbpp_sync.sv ----
module qbpp_sync
    import qbpp_pkg::*;
#(
    parameter int WIDTH = QBPP_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] stable_ff;

    // ****************************************
    // Two-flop synchroniser
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            meta_ff <= '1;
            stable_ff <= '1;
        end else begin
            meta_ff <= asyncIn;
            stable_ff <= meta_ff;
        end
    end

    assign syncOut = stable_ff;
endmodule

// ---- src/qbpp_pin_ctrl.sv ----
module qbpp_pin_ctrl
    import qbpp_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic latchBit,
    input wire logic [1:0] modeBits,
    input wire logic pinSync,
    output qbpp_drive_type drive
);
    qbpp_mode_type mode;
    logic [QBPP_STRONG_DELAY_CLKS-1:0] riseDly_ff;
    logic latchDly_ff;

    assign mode = qbpp_mode_type'({modeBits[0], modeBits[1]});

    // ****************************************
    // Rise delay for strong pull-up
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            latchDly_ff <= QBPP_LATCH_RST;
            riseDly_ff <= '0;
        end else begin
            latchDly_ff <= latchBit;
            riseDly_ff <= {riseDly_ff[QBPP_STRONG_DELAY_CLKS-2:0], latchBit & ~latchDly_ff};
        end
    end

    always_comb begin
        drive = '0;
        unique case (mode)
            QBPP_QUASI: begin
                drive.veryWeakPu = latchBit;
                drive.weakPu = latchBit & pinSync;
                drive.strongPu = latchBit & riseDly_ff[QBPP_STRONG_DELAY_CLKS-1];
                drive.outVal = 1'h0;
                drive.outEn = ~latchBit;
            end
            QBPP_PUSH_PULL: begin
                drive.outVal = latchBit;
                drive.outEn = 1'h1;
            end
            QBPP_INPUT_ONLY: begin
                drive = '0;
            end
            QBPP_OPEN_DRAIN: begin
                drive.outVal = 1'h0;
                drive.outEn = ~latchBit;
            end
        endcase
    end
endmodule

// ---- src/qbpp_port.sv ----
module qbpp_port
    import qbpp_pkg::*;
#(
    parameter int WIDTH = QBPP_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic latchWrEn,
    input wire logic [WIDTH-1:0] latchWrData,
    input wire logic modeLowWrEn,
    input wire logic [WIDTH-1:0] modeLowWrData,
    input wire logic modeHighWrEn,
    input wire logic [WIDTH-1:0] modeHighWrData,
    input wire logic rmwRead,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] readData_ff,
    output logic [WIDTH-1:0] pinOut_ff,
    output logic [WIDTH-1:0] pinOe_ff,
    output logic [WIDTH-1:0] veryWeakPu_ff,
    output logic [WIDTH-1:0] weakPu_ff,
    output logic [WIDTH-1:0] strongPu_ff
);
    logic [WIDTH-1:0] portDataLatch_ff;
    logic [WIDTH-1:0] modeSelectLow_ff;
    logic [WIDTH-1:0] modeSelectHigh_ff;
    logic [WIDTH-1:0] pinSync;
    qbpp_drive_type drv [WIDTH];

    // ****************************************
    // Pin input synchronisation
    // ****************************************
    qbpp_sync #(.WIDTH(WIDTH)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .asyncIn(pinIn),
        .syncOut(pinSync)
    );

    // ****************************************
    // Latch and mode registers
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            portDataLatch_ff <= {WIDTH{QBPP_LATCH_RST}};
        end else if (latchWrEn) begin
            portDataLatch_ff <= latchWrData;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            modeSelectLow_ff <= {WIDTH{QBPP_MODE_RST}};
            modeSelectHigh_ff <= {WIDTH{QBPP_MODE_RST}};
        end else begin
            if (modeLowWrEn) begin
                modeSelectLow_ff <= modeLowWrData;
            end
            if (modeHighWrEn) begin
                modeSelectHigh_ff <= modeHighWrData;
            end
        end
    end

    // ****************************************
    // Per-pin structure control
    // ****************************************
    for (genvar i = 0; i < WIDTH; i++) begin : g_pin
        qbpp_pin_ctrl u_pin (
            .clk(clk),
            .rstn(rstn),
            .latchBit(portDataLatch_ff[i]),
            .modeBits({modeSelectHigh_ff[i], modeSelectLow_ff[i]}),
            .pinSync(pinSync[i]),
            .drive(drv[i])
        );
    end

    // ****************************************
    // Registered pin controls
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinOut_ff <= '0;
            pinOe_ff <= '0;
            veryWeakPu_ff <= '1;
            weakPu_ff <= '1;
            strongPu_ff <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                pinOut_ff[i] <= drv[i].outVal;
                pinOe_ff[i] <= drv[i].outEn;
                veryWeakPu_ff[i] <= drv[i].veryWeakPu;
                weakPu_ff[i] <= drv[i].weakPu;
                strongPu_ff[i] <= drv[i].strongPu;
            end
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rstn) begin
            readData_ff <= '1;
        end else if (rmwRead) begin
            readData_ff <= portDataLatch_ff;
        end else begin
            readData_ff <= pinSync;
        end
    end
endmodule

// ---- test/qbpp_port_asserts.sv ----
module qbpp_port_chk
    import qbpp_pkg::*;
#(
    parameter int WIDTH = QBPP_WIDTH
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic latchWrEn,
    input wire logic [WIDTH-1:0] latchWrData,
    input wire logic rmwRead,
    input wire logic [WIDTH-1:0] pinIn,
    input wire logic [WIDTH-1:0] readData_ff,
    input wire logic [WIDTH-1:0] pinOut_ff,
    input wire logic [WIDTH-1:0] pinOe_ff,
    input wire logic [WIDTH-1:0] veryWeakPu_ff,
    input wire logic [WIDTH-1:0] weakPu_ff,
    input wire logic [WIDTH-1:0] strongPu_ff
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [WIDTH-1:0] lat_ff;
    always_ff @(posedge clk) lat_ff <= !rstn ? '1 : latchWrEn ? latchWrData : lat_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_pu; (pinOe_ff & (veryWeakPu_ff | weakPu_ff | strongPu_ff)) == '0; endproperty
    a_pu: assert property (p_pu) else $error("pull-up on driven pin");
    property p_vw; (veryWeakPu_ff & ~$past(lat_ff)) == '0; endproperty
    a_vw: assert property (p_vw) else $error("pull-up with latch low");
    property p_wk; (weakPu_ff & ~veryWeakPu_ff) == '0; endproperty
    a_wk: assert property (p_wk) else $error("stray weak pull-up");
    property p_st; $rose(veryWeakPu_ff[0]) && $past(pinOe_ff[0]) && !$past(pinOut_ff[0])
        |-> !strongPu_ff[0] ##1 !strongPu_ff[0] ##1 strongPu_ff[0]; endproperty
    a_st: assert property (p_st) else $error("strong pull-up timing");
    property p_out; (pinOe_ff & (pinOut_ff ^ $past(lat_ff))) == '0; endproperty
    a_out: assert property (p_out) else $error("driven level");
    property p_rmw; rmwRead |=> readData_ff == $past(lat_ff); endproperty
    a_rmw: assert property (p_rmw) else $error("latch read");
    property p_rd; !rmwRead && $past(rstn) && $past(rstn, 2) |=> readData_ff == $past(pinIn, 3); endproperty
    a_rd: assert property (p_rd) else $error("pin read");
    property p_rst; disable iff (1'b0) !rstn |=> pinOe_ff == '0 && veryWeakPu_ff == '1 && readData_ff == '1;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state");
    c_st: cover property ($rose(strongPu_ff[0]));
    c_rmw: cover property (rmwRead && pinOe_ff != '0);
    c_rst: cover property ($rose(rstn));
endmodule
bind qbpp_port qbpp_port_chk #(.WIDTH(WIDTH)) u_chk (.clk(clk), .rstn(rstn), .latchWrEn(latchWrEn),
    .latchWrData(latchWrData), .rmwRead(rmwRead), .pinIn(pinIn), .readData_ff(readData_ff), .pinOut_ff(pinOut_ff),
    .pinOe_ff(pinOe_ff), .veryWeakPu_ff(veryWeakPu_ff), .weakPu_ff(weakPu_ff), .strongPu_ff(strongPu_ff));

// ---- test/qbpp_ext_model.sv ----
module qbpp_ext_model
    import qbpp_pkg::*;
(
    input wire logic clk,
    input wire logic [QBPP_WIDTH-1:0] pinOut,
    input wire logic [QBPP_WIDTH-1:0] pinOe,
    input wire logic [QBPP_WIDTH-1:0] pullUp,
    input wire logic [QBPP_WIDTH-1:0] extLow,
    output logic [QBPP_WIDTH-1:0] pinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [QBPP_WIDTH-1:0] flt_ff = '0;
    // An undriven, unpulled pin wanders every cycle
    always_ff @(posedge clk) flt_ff <= ~flt_ff;
    assign pinIn = (pinOe & pinOut) | (~pinOe & ~extLow & (pullUp | flt_ff));
endmodule

// ---- test/test_quasi_bidir_port_pins.sv ----
module test_quasi_bidir_port_pins import qbpp_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, rstn = 1'b0, rmwRead = 1'b0, chk = 1'b0, chkD = 1'b0;
    logic [2:0] wrEn = '0;
    logic [7:0] lWr = '0, mlWr = '0, mhWr = '0, extLow = '0, l, ml, mh, ex, oe, pinIn, rd, pOut, pOe, vw, wk, st;
    logic [7:0] qh, pp;
    logic [39:0] note;
    logic [39:0] q[$];
    int numErrors = 0, testsRun = 0;
    always #2 clk = ~clk;
    qbpp_port u_dut (.clk(clk), .rstn(rstn), .latchWrEn(wrEn[0]), .latchWrData(lWr), .modeLowWrEn(wrEn[1]),
        .modeLowWrData(mlWr), .modeHighWrEn(wrEn[2]), .modeHighWrData(mhWr), .rmwRead(rmwRead), .pinIn(pinIn),
        .readData_ff(rd), .pinOut_ff(pOut), .pinOe_ff(pOe), .veryWeakPu_ff(vw), .weakPu_ff(wk), .strongPu_ff(st));
    qbpp_ext_model u_ext (.clk(clk), .pinOut(pOut), .pinOe(pOe), .pullUp(vw | wk | st), .extLow(extLow),
        .pinIn(pinIn));
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            numErrors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic endOfTest();
        $display("checks %0d errors %0d", testsRun, numErrors);
        if (numErrors == 0 && testsRun > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        chkD <= chk;
        if (chkD) begin
            note = q.pop_front();
            check("pinOe", pOe, note[39:32]);
            check("pinOut", pOut, note[31:24]);
            check("veryWeakPu", vw, note[23:16]);
            check("weakPu", wk, note[15:8]);
            check("strongPu", st, 8'h00);
            check("readData", rd, note[7:0]);
        end
    end
    initial begin
        void'($urandom(32'hADCD));
        for (int t = 0; t < 41; t++) begin
            @(posedge clk);
            if (t % 20 == 0) begin
                rstn <= 1'b0;
                extLow <= '0;
                {l, ml, mh, ex} = {8'hFF, 24'h0};
                repeat (4) @(posedge clk);
                rstn <= 1'b1;
            end else begin
                // Pin 0 stays quasi so its strong pull-up gets exercised
                {l, ml, mh, ex} = $urandom & 32'hFFFEFEFF;
                ex = ex | ~(~ml & ~mh & l);
                wrEn <= 3'h7;
                {lWr, mlWr, mhWr, extLow} <= {l, ml, mh, ex};
                @(posedge clk);
                wrEn <= 3'h0;
                repeat (6) @(posedge clk);
            end
            oe = (~ml & ~mh & ~l) | (mh & ~ml) | (ml & mh & ~l);
            chk <= 1'b1;
            // Strong pull-up is a short pulse, long over by the time of the checks
            qh = ~ml & ~mh & l;
            pp = mh & ~ml;
            q.push_back({oe, pp & l, qh, qh & ~ex, (oe & pp & l) | (~oe & ~ex)});
            @(posedge clk);
            rmwRead <= 1'b1;
            q.push_back({oe, pp & l, qh, qh & ~ex, l});
            @(posedge clk);
            {chk, rmwRead} <= 2'h0;
            $display("test %0d done", t);
        end
        repeat (2) @(posedge clk);
        if (q.size() != 0) numErrors++;
        endOfTest();
    end
endmodule
